//--- common/flash_ctl_pkg.sv
package flash_ctl_pkg;

  // Register byte offsets on the bus.
  localparam logic [7:0] CMD_STAT_OFS  = 8'h00;
  localparam logic [7:0] PAGE_SEL_OFS  = 8'h04;
  localparam logic [7:0] FREQ_HI_OFS   = 8'h08;
  localparam logic [7:0] FREQ_LO_OFS   = 8'h0C;
  localparam logic [7:0] PROG_ADDR_OFS = 8'h10;
  localparam logic [7:0] PROG_DATA_OFS = 8'h14;
  localparam logic [7:0] OPTION_OFS    = 8'h18;

  // Command values.
  localparam logic [7:0] CMD_KEY1     = 8'h73;
  localparam logic [7:0] CMD_KEY2     = 8'h8C;
  localparam logic [7:0] CMD_PG_ERASE = 8'h95;
  localparam logic [7:0] CMD_MS_ERASE = 8'h63;
  localparam logic [7:0] CMD_SECT     = 8'h5E;

  // Status codes.
  localparam logic [5:0] ST_LOCKED   = 6'h00;
  localparam logic [5:0] ST_KEY1     = 6'h01;
  localparam logic [5:0] ST_KEY2     = 6'h02;
  localparam logic [5:0] ST_UNLOCKED = 6'h03;
  localparam logic [5:0] ST_SECT     = 6'h04;
  localparam logic [5:0] ST_PROG     = 6'h08;
  localparam logic [5:0] ST_PERASE   = 6'h10;
  localparam logic [5:0] ST_MERASE   = 6'h20;

  // Array geometry.
  localparam int unsigned PAGE_BYTES   = 512;
  localparam int unsigned ROWS_PER_PG  = 8;
  localparam int unsigned ROW_BYTES    = 64;
  localparam int unsigned NUM_PAGES    = 8;
  localparam int unsigned ARRAY_BYTES  = 4096;
  localparam int unsigned PAGE_LSB     = 9;
  localparam logic [6:0]  INFO_PAGE    = 7'h7F;
  localparam int unsigned INFO_EN_BIT  = 7;
  localparam int unsigned OPTION_BYTES = 2;
  localparam logic [7:0]  ERASED_BYTE  = 8'hFF;

  // Option bit positions within option byte 0.
  localparam int unsigned WP_BIT  = 7;
  localparam int unsigned HSW_BIT = 6;

  // Operation times in microseconds and the microsecond tick divider.
  localparam logic [17:0] PROG_TIME_US = 18'd40;
  localparam logic [16:0] HZ_PER_KHZ_US = 17'd1000;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [31:0] adr;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

endpackage

//--- design/flash_program_erase_control.sv
`timescale 1ns/100ps
// How it works
// - Array is pages of 512 bytes, eight 64-byte rows; page is smallest erase.
// - Protection sectors are 512 bytes, one sector per erase page.
// - The lowest two bytes hold option bits, not ordinary program content.
// - A separate information area appears at FE00H to FFFFH when enabled.
// - High and low frequency bytes form a 16-bit kilohertz clock value.
// - Both option bits zero blocks user programming and erases; debug mass erase stays.
// - Write-protect option bit one allows programming and page erase; mass erase still needs debug.
// - Every reset returns the controller to the locked state.
// - Second page select mismatch relocks; a match makes the page active.
// - Command 95H erases the active page only if its sector is unprotected or debug is active.
// - Any other command after unlock, or after programming, relocks.
// - Mass erase is refused from user code, accepted only from debug.
// - Byte writes anywhere in the unlocked page keep the page unlocked.
// - Commands 73H then 5EH route next page-select write to sector protection.
// - Sector protection bits clear to zero on reset.
// - A set sector protection bit blocks programming and erase of that sector unless debug is active.
// - Register writes cannot clear a set sector protection bit.
// - Mass erase context programs anywhere; page context only the selected page.
// - Programming only clears bits; erased bytes read FFH.
// - The core is stalled while an operation runs; clock keeps running.
// - Status is a 6-bit state code readable at the command address.
// - Command writes and status reads share one address.
// - The 7-bit page number gives address bits 15 down to 9.
// - A completed erase returns the controller to the locked state.
module flash_program_erase_control #(
  parameter logic [17:0] PAGE_ERASE_US = 18'd10000,
  parameter logic [17:0] MASS_ERASE_US = 18'd200000
) (
  input  wire logic                  clk_sys_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  ce_i,
  input  wire logic                  debug_i,
  input  wire flash_ctl_pkg::wb_req_t wb_req_i,
  output      flash_ctl_pkg::wb_rsp_t wb_rsp_o,
  output      logic                  cpu_stall_o
);

  typedef enum logic [7:0] {
    S_LOCKED   = 8'b0000_0001,
    S_KEY1     = 8'b0000_0010,
    S_KEY2     = 8'b0000_0100,
    S_UNLOCKED = 8'b0000_1000,
    S_SECT     = 8'b0001_0000,
    S_PROG     = 8'b0010_0000,
    S_PERASE   = 8'b0100_0000,
    S_MERASE   = 8'b1000_0000
  } state_t;

  state_t      state_q;
  state_t      state_d;
  logic [7:0]  mem [flash_ctl_pkg::ARRAY_BYTES];
  logic [7:0]  info [flash_ctl_pkg::PAGE_BYTES];
  logic [7:0]  page_q;
  logic [7:0]  prot_q;
  logic [7:0]  freq_hi_q;
  logic [7:0]  freq_lo_q;
  logic [15:0] paddr_q;
  logic [7:0]  pdata_q;
  logic        ack_q;
  logic [31:0] rdat_q;
  logic        stall_q;
  logic        dbg_meta_q;
  logic        dbg_q;
  logic [16:0] acc_q;
  logic [17:0] us_q;
  logic [17:0] tgt_q;
  logic [12:0] walk_q;
  logic        erase_info_q;

  wire         req      = wb_req_i.cyc & wb_req_i.stb & ~ack_q;
  wire         wr_acc   = ce_i & req & wb_req_i.we & wb_req_i.sel[0];
  wire  [7:0]  ofs      = wb_req_i.adr[7:0];
  wire  [7:0]  wdat     = wb_req_i.dat[7:0];
  wire         cmd_wr   = wr_acc & (ofs == flash_ctl_pkg::CMD_STAT_OFS);
  wire         ps_wr    = wr_acc & (ofs == flash_ctl_pkg::PAGE_SEL_OFS);
  wire         pd_wr    = wr_acc & (ofs == flash_ctl_pkg::PROG_DATA_OFS);

  wire  [15:0] khz      = {freq_hi_q, freq_lo_q};
  wire  [6:0]  act_page = page_q[6:0];
  wire         info_en  = page_q[flash_ctl_pkg::INFO_EN_BIT];
  wire  [7:0]  opt_byte = mem[0];
  wire         wp_bit   = opt_byte[flash_ctl_pkg::WP_BIT];
  wire         hsw_bit  = opt_byte[flash_ctl_pkg::HSW_BIT];
  wire         opt_ok   = dbg_q | wp_bit | hsw_bit;

  // Page number bits 15:9 address the array; only pages 0..7 exist.
  function automatic logic page_in_array(input logic [6:0] pg);
    page_in_array = (pg[6:3] == 4'h0);
  endfunction

  function automatic logic sect_prot(input logic [6:0] pg, input logic [7:0] prot);
    sect_prot = prot[pg[2:0]];
  endfunction

  wire  [6:0]  prog_page = paddr_q[15:flash_ctl_pkg::PAGE_LSB];
  wire         prog_info = info_en & (prog_page == flash_ctl_pkg::INFO_PAGE);
  wire         prog_arr  = page_in_array(prog_page) & (dbg_q | (prog_page == act_page));
  wire         prog_prot = ~dbg_q & sect_prot(prog_page, prot_q);
  wire         prog_ok   = opt_ok & (prog_info | (prog_arr & ~prog_prot));
  wire         perase_ok = opt_ok & ((info_en & act_page == flash_ctl_pkg::INFO_PAGE) |
                            (page_in_array(act_page) & (dbg_q | ~sect_prot(act_page, prot_q))));
  wire         merase_ok = dbg_q;
  wire         pg_match  = (wdat == page_q);

  wire         busy      = (state_q == S_PROG) | (state_q == S_PERASE) | (state_q == S_MERASE);
  wire  [12:0] walk_len  = (state_q == S_MERASE) ? 13'(flash_ctl_pkg::ARRAY_BYTES) :
                           13'(flash_ctl_pkg::PAGE_BYTES);
  wire         walk_done = (state_q == S_PROG) | (walk_q >= walk_len);
  wire         op_done   = busy & (us_q >= tgt_q) & walk_done;
  wire  [16:0] acc_sum   = acc_q + flash_ctl_pkg::HZ_PER_KHZ_US;
  wire         us_tick   = (acc_sum >= {1'b0, khz});

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_LOCKED: begin
        if (cmd_wr && wdat == flash_ctl_pkg::CMD_KEY1) begin
          state_d = S_KEY1;
        end
      end
      S_KEY1: begin
        if (cmd_wr) begin
          if (wdat == flash_ctl_pkg::CMD_KEY2) begin
            state_d = S_KEY2;
          end else if (wdat == flash_ctl_pkg::CMD_SECT) begin
            state_d = S_SECT;
          end else begin
            state_d = S_LOCKED;
          end
        end
      end
      S_KEY2: begin
        if (cmd_wr) begin
          state_d = S_LOCKED;
        end else if (ps_wr) begin
          state_d = pg_match ? S_UNLOCKED : S_LOCKED;
        end
      end
      S_UNLOCKED: begin
        if (cmd_wr) begin
          if (wdat == flash_ctl_pkg::CMD_PG_ERASE && perase_ok) begin
            state_d = S_PERASE;
          end else if (wdat == flash_ctl_pkg::CMD_MS_ERASE && merase_ok) begin
            state_d = S_MERASE;
          end else begin
            state_d = S_LOCKED;
          end
        end else if (pd_wr && prog_ok) begin
          state_d = S_PROG;
        end
      end
      S_SECT: begin
        if (cmd_wr || ps_wr) begin
          state_d = S_LOCKED;
        end
      end
      S_PROG: begin
        if (op_done) begin
          state_d = S_UNLOCKED;
        end
      end
      S_PERASE, S_MERASE: begin
        if (op_done) begin
          state_d = S_LOCKED;
        end
      end
      default: state_d = S_LOCKED;
    endcase
  end

  wire  [5:0]  stat_code = (state_q == S_KEY1)   ? flash_ctl_pkg::ST_KEY1 :
                           (state_q == S_KEY2)   ? flash_ctl_pkg::ST_KEY2 :
                           (state_q == S_UNLOCKED) ? flash_ctl_pkg::ST_UNLOCKED :
                           (state_q == S_SECT)   ? flash_ctl_pkg::ST_SECT :
                           (state_q == S_PROG)   ? flash_ctl_pkg::ST_PROG :
                           (state_q == S_PERASE) ? flash_ctl_pkg::ST_PERASE :
                           (state_q == S_MERASE) ? flash_ctl_pkg::ST_MERASE :
                           flash_ctl_pkg::ST_LOCKED;

  wire         rd_info  = info_en & (paddr_q[15:flash_ctl_pkg::PAGE_LSB] == flash_ctl_pkg::INFO_PAGE);
  wire  [7:0]  rd_byte  = rd_info ? info[paddr_q[8:0]] :
                          page_in_array(paddr_q[15:9]) ? mem[paddr_q[11:0]] : flash_ctl_pkg::ERASED_BYTE;
  wire  [7:0]  rd_mux   = (ofs == flash_ctl_pkg::CMD_STAT_OFS)  ? {2'b00, stat_code} :
                          (ofs == flash_ctl_pkg::PAGE_SEL_OFS)  ? page_q :
                          (ofs == flash_ctl_pkg::FREQ_HI_OFS)   ? freq_hi_q :
                          (ofs == flash_ctl_pkg::FREQ_LO_OFS)   ? freq_lo_q :
                          (ofs == flash_ctl_pkg::PROG_DATA_OFS) ? rd_byte :
                          (ofs == flash_ctl_pkg::OPTION_OFS)    ? {6'h00, wp_bit, hsw_bit} : 8'h00;
  wire  [31:0] rd_word  = (ofs == flash_ctl_pkg::PROG_ADDR_OFS) ? {16'h0000, paddr_q} : {24'h000000, rd_mux};

  // Bus, state and control registers.
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q    <= S_LOCKED;
      page_q     <= 8'h00;
      prot_q     <= 8'h00;
      freq_hi_q  <= 8'h00;
      freq_lo_q  <= 8'h00;
      paddr_q    <= 16'h0000;
      pdata_q    <= 8'h00;
      ack_q      <= 1'b0;
      rdat_q     <= 32'h0000_0000;
      stall_q    <= 1'b0;
      dbg_meta_q <= 1'b0;
      dbg_q      <= 1'b0;
    end else if (ce_i) begin
      dbg_meta_q <= debug_i;
      dbg_q      <= dbg_meta_q;
      state_q    <= state_d;
      ack_q      <= req;
      stall_q    <= (state_d == S_PROG) | (state_d == S_PERASE) | (state_d == S_MERASE);
      if (req) begin
        rdat_q <= wb_req_i.we ? 32'h0000_0000 : rd_word;
      end
      if (ps_wr && (state_q == S_LOCKED || state_q == S_KEY1)) begin
        page_q <= wdat;
      end
      if (ps_wr && state_q == S_SECT) begin
        prot_q <= prot_q | wdat;
      end
      if (wr_acc && ofs == flash_ctl_pkg::FREQ_HI_OFS) begin
        freq_hi_q <= wdat;
      end
      if (wr_acc && ofs == flash_ctl_pkg::FREQ_LO_OFS) begin
        freq_lo_q <= wdat;
      end
      if (wr_acc && ofs == flash_ctl_pkg::PROG_ADDR_OFS && !busy) begin
        paddr_q[7:0] <= wdat;
        if (wb_req_i.sel[1]) begin
          paddr_q[15:8] <= wb_req_i.dat[15:8];
        end
      end
      if (pd_wr && !busy) begin
        pdata_q <= wdat;
      end
    end
  end

  // Operation timer and erase walk.
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      acc_q        <= 17'h0_0000;
      us_q         <= 18'h0_0000;
      tgt_q        <= 18'h0_0000;
      walk_q       <= 13'h0000;
      erase_info_q <= 1'b0;
    end else if (ce_i) begin
      if (!busy) begin
        acc_q  <= 17'h0_0000;
        us_q   <= 18'h0_0000;
        walk_q <= 13'h0000;
        tgt_q  <= (state_d == S_PERASE) ? PAGE_ERASE_US :
                  (state_d == S_MERASE) ? MASS_ERASE_US : flash_ctl_pkg::PROG_TIME_US;
        erase_info_q <= info_en & (act_page == flash_ctl_pkg::INFO_PAGE);
      end else begin
        acc_q <= us_tick ? 17'(acc_sum - {1'b0, khz}) : acc_sum;
        if (us_tick && us_q < tgt_q) begin
          us_q <= us_q + 18'h0_0001;
        end
        if (!walk_done) begin
          walk_q <= walk_q + 13'h0001;
        end
      end
    end
  end

  // The array itself is not reset: it is non-volatile.
  wire  [11:0] erase_addr = (state_q == S_MERASE) ? walk_q[11:0] : {act_page[2:0], walk_q[8:0]};

  always_ff @(posedge clk_sys_i) begin
    if (ce_i) begin
      if (busy && state_q != S_PROG && !walk_done) begin
        if (erase_info_q && state_q == S_PERASE) begin
          info[walk_q[8:0]] <= flash_ctl_pkg::ERASED_BYTE;
        end else begin
          mem[erase_addr] <= flash_ctl_pkg::ERASED_BYTE;
        end
      end
      if (state_q == S_PROG && op_done) begin
        if (prog_info) begin
          info[paddr_q[8:0]] <= info[paddr_q[8:0]] & pdata_q;
        end else begin
          mem[paddr_q[11:0]] <= mem[paddr_q[11:0]] & pdata_q;
        end
      end
    end
  end

  assign wb_rsp_o.ack = ack_q;
  assign wb_rsp_o.dat = rdat_q;
  assign cpu_stall_o  = stall_q;

  unlock_match_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (state_q == S_KEY2 && ps_wr && !cmd_wr && pg_match) |=> (state_q == S_UNLOCKED))
    else $error("matching page select did not unlock");
  unlock_mismatch_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (state_q == S_KEY2 && ps_wr && !pg_match) |=> (state_q == S_LOCKED))
    else $error("mismatched page select did not relock");
  bad_cmd_lock_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (state_q == S_UNLOCKED && cmd_wr && wdat != flash_ctl_pkg::CMD_PG_ERASE &&
     wdat != flash_ctl_pkg::CMD_MS_ERASE) |=> (state_q == S_LOCKED))
    else $error("invalid command did not relock");
  prot_sticky_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    ##1 (($past(prot_q) & ~prot_q) == 8'h00))
    else $error("sector protection bit cleared");
  prot_erase_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (state_q == S_UNLOCKED && cmd_wr && !dbg_q && sect_prot(act_page, prot_q) && !info_en) |=>
    (state_q != S_PERASE))
    else $error("protected sector erase started");
  mass_user_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (cmd_wr && !dbg_q) |=> (state_q != S_MERASE))
    else $error("user mass erase accepted");
  option_block_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (state_q == S_UNLOCKED && pd_wr && !dbg_q && !wp_bit && !hsw_bit) |=> (state_q != S_PROG))
    else $error("program started with option protection");
  stall_busy_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (state_q == S_PROG || state_q == S_PERASE) |-> cpu_stall_o)
    else $error("core not stalled during operation");
  erase_relock_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (state_q == S_PERASE && op_done && ce_i) |=> (state_q == S_LOCKED) ##1 !cpu_stall_o)
    else $error("erase completion did not relock");
  status_read_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (ce_i && req && !wb_req_i.we && ofs == flash_ctl_pkg::CMD_STAT_OFS && state_q == S_UNLOCKED) |=>
    (wb_rsp_o.ack && wb_rsp_o.dat == 32'h0000_0003))
    else $error("status read wrong while unlocked");

endmodule

//--- tb/wb_master_model.sv
`timescale 1ns/100ps
module wb_master_model (
  input  wire logic                   clk_i,
  input  wire flash_ctl_pkg::wb_rsp_t rsp_i,
  output      flash_ctl_pkg::wb_req_t req_o,
  output      logic                   hang_o
);
  initial begin
    req_o = '0;
    hang_o = 1'h0;
  end

  // Holds one classic cycle until ack is sampled. On release every line shows its
  // inverse, so a slave that keeps using stale address or data is caught.
  task automatic xfer(input logic wr, input logic [7:0] ofs, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    req_o <= '{cyc: 1'h1, stb: 1'h1, we: wr, sel: 4'hF, adr: {24'h0, ofs}, dat: wd};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (rsp_i.ack !== 1'h1 && n < 100);
    rd = rsp_i.dat;
    req_o <= ~req_o;
    if (n >= 100) begin
      hang_o <= 1'h1;
    end
  endtask
endmodule

//--- tb/flash_program_erase_control_tb.sv
`timescale 1ns/100ps
module flash_program_erase_control_tb;
  logic                   clk_sys_i = 1'h0;
  logic                   sys_rst_i = 1'h1;
  logic                   debug_i   = 1'h0;
  flash_ctl_pkg::wb_req_t wb_req;
  flash_ctl_pkg::wb_rsp_t wb_rsp;
  logic                   cpu_stall;
  logic                   bus_hang;
  int                     error_cnt = 0;
  int                     total_checks = 0;
  int                     seed = 31;
  logic [31:0]            rdat;
  logic [7:0]             b0;
  logic [7:0]             b1;
  logic [7:0]             exp_b;
  logic [15:0]            a;

  always #4 clk_sys_i = ~clk_sys_i;

  flash_program_erase_control #(.PAGE_ERASE_US(18'h2), .MASS_ERASE_US(18'h2)) dut_u (
    .clk_sys_i  (clk_sys_i),
    .sys_rst_i  (sys_rst_i),
    .ce_i       (1'h1),
    .debug_i    (debug_i),
    .wb_req_i   (wb_req),
    .wb_rsp_o   (wb_rsp),
    .cpu_stall_o(cpu_stall)
  );

  wb_master_model host_u (
    .clk_i (clk_sys_i),
    .rsp_i (wb_rsp),
    .req_o (wb_req),
    .hang_o(bus_hang)
  );

  function automatic logic [7:0] after_prog(input logic [7:0] old, input logic [7:0] d);
    return old & d;
  endfunction

  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    host_u.xfer(1'h1, ofs, {24'h0, d}, rdat);
  endtask

  task automatic cmd(input logic [7:0] d);
    wr(flash_ctl_pkg::CMD_STAT_OFS, d);
  endtask

  task automatic status(input logic [5:0] exp);
    host_u.xfer(1'h0, flash_ctl_pkg::CMD_STAT_OFS, 32'h0, rdat);
    check("status", rdat, {26'h0, exp});
  endtask

  task automatic poll(input logic [5:0] exp);
    int n;
    n = 0;
    host_u.xfer(1'h0, flash_ctl_pkg::CMD_STAT_OFS, 32'h0, rdat);
    while (rdat !== {26'h0, exp} && n < 6000) begin
      host_u.xfer(1'h0, flash_ctl_pkg::CMD_STAT_OFS, 32'h0, rdat);
      n++;
    end
    check("end status", rdat, {26'h0, exp});
    if (n >= 6000) begin
      print_verdict();
    end
  endtask

  task automatic unlock(input logic [7:0] pg);
    wr(flash_ctl_pkg::PAGE_SEL_OFS, pg);
    cmd(flash_ctl_pkg::CMD_KEY1);
    cmd(flash_ctl_pkg::CMD_KEY2);
    wr(flash_ctl_pkg::PAGE_SEL_OFS, pg);
  endtask

  task automatic rd_byte(input logic [15:0] ad, input logic [7:0] exp);
    host_u.xfer(1'h1, flash_ctl_pkg::PROG_ADDR_OFS, {16'h0, ad}, rdat);
    host_u.xfer(1'h0, flash_ctl_pkg::PROG_DATA_OFS, 32'h0, rdat);
    check("array byte", rdat, {24'h0, exp});
  endtask

  // A refused byte write leaves the controller unlocked and the core running.
  task automatic prog(input logic [15:0] ad, input logic [7:0] d, input logic ok);
    host_u.xfer(1'h1, flash_ctl_pkg::PROG_ADDR_OFS, {16'h0, ad}, rdat);
    wr(flash_ctl_pkg::PROG_DATA_OFS, d);
    status(ok ? flash_ctl_pkg::ST_PROG : flash_ctl_pkg::ST_UNLOCKED);
    check("stall", {31'h0, cpu_stall}, {31'h0, ok});
    poll(flash_ctl_pkg::ST_UNLOCKED);
  endtask

  always @(posedge clk_sys_i) begin
    if (bus_hang === 1'h1) begin
      error_cnt++;
      print_verdict();
    end
  end

  initial begin
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 1'h0;
    status(flash_ctl_pkg::ST_LOCKED);
    host_u.xfer(1'h0, 8'h1C, 32'h0, rdat);
    check("unmapped", rdat, 32'h0);
    // A 20000 kHz value stays inside the supported clock range and keeps operations short.
    wr(flash_ctl_pkg::FREQ_HI_OFS, 8'h4E);
    wr(flash_ctl_pkg::FREQ_LO_OFS, 8'h20);
    unlock(8'h00);
    status(flash_ctl_pkg::ST_UNLOCKED);
    cmd(flash_ctl_pkg::CMD_MS_ERASE);
    status(flash_ctl_pkg::ST_LOCKED);
    wr(flash_ctl_pkg::PAGE_SEL_OFS, 8'h01);
    cmd(flash_ctl_pkg::CMD_KEY1);
    status(flash_ctl_pkg::ST_KEY1);
    cmd(flash_ctl_pkg::CMD_KEY2);
    status(flash_ctl_pkg::ST_KEY2);
    wr(flash_ctl_pkg::PAGE_SEL_OFS, 8'h02);
    status(flash_ctl_pkg::ST_LOCKED);
    debug_i <= 1'h1;
    repeat (3) @(posedge clk_sys_i);
    unlock(8'h00);
    cmd(flash_ctl_pkg::CMD_MS_ERASE);
    status(flash_ctl_pkg::ST_MERASE);
    check("stall", {31'h0, cpu_stall}, 32'h1);
    poll(flash_ctl_pkg::ST_LOCKED);
    check("stall", {31'h0, cpu_stall}, 32'h0);
    debug_i <= 1'h0;
    repeat (3) @(posedge clk_sys_i);
    host_u.xfer(1'h0, flash_ctl_pkg::OPTION_OFS, 32'h0, rdat);
    check("option bits", rdat, 32'h3);
    unlock(8'h01);
    for (int i = 0; i < 3; i++) begin
      a = 16'h0200 + 16'(i) * 16'h00FF;
      b0 = 8'($random(seed));
      b1 = 8'($random(seed));
      rd_byte(a, flash_ctl_pkg::ERASED_BYTE);
      prog(a, b0, 1'h1);
      prog(a, b1, 1'h1);
      exp_b = after_prog(after_prog(flash_ctl_pkg::ERASED_BYTE, b0), b1);
      rd_byte(a, exp_b);
    end
    prog(16'h0400, 8'h00, 1'h0);
    rd_byte(16'h0400, flash_ctl_pkg::ERASED_BYTE);
    cmd(8'h11);
    status(flash_ctl_pkg::ST_LOCKED);
    cmd(flash_ctl_pkg::CMD_KEY1);
    cmd(flash_ctl_pkg::CMD_SECT);
    status(flash_ctl_pkg::ST_SECT);
    wr(flash_ctl_pkg::PAGE_SEL_OFS, 8'h02);
    status(flash_ctl_pkg::ST_LOCKED);
    unlock(8'h01);
    prog(16'h0201, 8'h00, 1'h0);
    rd_byte(16'h0201, flash_ctl_pkg::ERASED_BYTE);
    cmd(flash_ctl_pkg::CMD_PG_ERASE);
    status(flash_ctl_pkg::ST_LOCKED);
    cmd(flash_ctl_pkg::CMD_KEY1);
    cmd(flash_ctl_pkg::CMD_SECT);
    wr(flash_ctl_pkg::PAGE_SEL_OFS, 8'h00);
    unlock(8'h01);
    cmd(flash_ctl_pkg::CMD_PG_ERASE);
    status(flash_ctl_pkg::ST_LOCKED);
    rd_byte(16'h03FE, exp_b);
    unlock(8'h02);
    prog(16'h05FF, 8'($random(seed)) & 8'h7F, 1'h1);
    cmd(flash_ctl_pkg::CMD_PG_ERASE);
    status(flash_ctl_pkg::ST_PERASE);
    check("stall", {31'h0, cpu_stall}, 32'h1);
    poll(flash_ctl_pkg::ST_LOCKED);
    rd_byte(16'h05FF, flash_ctl_pkg::ERASED_BYTE);
    rd_byte(16'h03FE, exp_b);
    unlock(8'h00);
    prog(16'h0000, 8'h3F, 1'h1);
    host_u.xfer(1'h0, flash_ctl_pkg::OPTION_OFS, 32'h0, rdat);
    check("option bits", rdat, 32'h0);
    cmd(8'h11);
    unlock(8'h03);
    prog(16'h0600, 8'h00, 1'h0);
    rd_byte(16'h0600, flash_ctl_pkg::ERASED_BYTE);
    cmd(flash_ctl_pkg::CMD_PG_ERASE);
    status(flash_ctl_pkg::ST_LOCKED);
    print_verdict();
  end
endmodule
